// ==== hdl/pad_regs_pkg.sv ====
/*
  Constants and types for the pad drive/slew/pull register bank: register
  indices, field positions, reset values and the pad configuration carrier.
  Assumes a 32-bit classic Wishbone bus with byte addresses of four times the
  register index.
*/
// Notes on behaviour
// - audio transmit pad register, reset 0x0008, pull-down
// - slave control clock pad register, reset 0x0008
// - slave control data-out pad register, reset 0x0008
// - select/address-0 pad register, reset 0x0018, pulled up
// - data-in/address-1 pad register, reset 0x0018, pulled up
// - master control clock pad register, reset 0x0008
// - bits 3:2 slew select, reset fast
// - bits 1:0 drive select, reset lowest
// - bits 15:5 reserved, read/write, reset zero
package pad_regs_pkg;

  // ------------------------------------------------------------
  // register map: indices, byte address is index times four
  // ------------------------------------------------------------
  localparam int NUM_REGS = 6;
  localparam int IDX_W = 16;
  localparam int ADR_W = 18;
  localparam logic [IDX_W-1:0] AUDIO_TX_PAD_CTRL_IDX = 16'hf798;
  localparam logic [IDX_W-1:0] CTRL_CLOCK_PAD_CTRL_IDX = 16'hf799;
  localparam logic [IDX_W-1:0] CTRL_DATAOUT_PAD_CTRL_IDX = 16'hf79a;
  localparam logic [IDX_W-1:0] SELECT_ADDR0_PAD_CTRL_IDX = 16'hf79b;
  localparam logic [IDX_W-1:0] DATAIN_ADDR1_PAD_CTRL_IDX = 16'hf79c;
  localparam logic [IDX_W-1:0] MASTER_CLOCK_PAD_CTRL_IDX = 16'hf79d;
  localparam int ADR_IDX_LSB = 2;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int BUS_W = 32;
  localparam int SEL_W = 4;
  localparam int PULL_BIT = 4;
  localparam int SLEW_MSB = 3;
  localparam int SLEW_LSB = 2;
  localparam int DRIVE_MSB = 1;
  localparam int DRIVE_LSB = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [REG_W-1:0] RESET_PULL_OFF = 16'h0008;
  localparam logic [REG_W-1:0] RESET_PULL_ON = 16'h0018;

  typedef enum logic [1:0] {
    SLEW_SLOWEST = 2'h0,
    SLEW_SLOW = 2'h1,
    SLEW_FAST = 2'h2,
    SLEW_FASTEST = 2'h3
  } slew_t;

  typedef enum logic [1:0] {
    DRIVE_LOWEST = 2'h0,
    DRIVE_LOW = 2'h1,
    DRIVE_HIGH = 2'h2,
    DRIVE_HIGHEST = 2'h3
  } drive_t;

  typedef struct packed {
    logic pull_en;
    slew_t slew;
    drive_t drive;
  } pad_cfg_t;

endpackage

// ==== hdl/pad_cfg_reg.sv ====
/*
  One 16-bit pad configuration register with byte-lane writes.
  Assumes the write strobe is a single-cycle pulse from the bus slave.
*/
`timescale 1ns/1ns
module pad_cfg_reg #(
  parameter logic [pad_regs_pkg::REG_W-1:0] RESET_VAL = pad_regs_pkg::RESET_PULL_OFF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [1:0] sel_in,
  input wire logic [pad_regs_pkg::REG_W-1:0] dat_in,
  output logic [pad_regs_pkg::REG_W-1:0] value_out
);

  // ------------------------------------------------------------
  // byte lanes; reserved upper bits stored like any other
  // ------------------------------------------------------------
  // lanes only pick the next value, so the word keeps a single flop process
  logic [pad_regs_pkg::REG_W-1:0] value_reg;
  wire logic [pad_regs_pkg::REG_W-1:0] value_next;

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_lane
      assign value_next[b*8 +: 8] = (wr_in && sel_in[b]) ? dat_in[b*8 +: 8] : value_reg[b*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg;

endmodule

// ==== hdl/wb_access_ctrl.sv ====
/*
  Classic Wishbone handshake for a register slave: one ack per request and a
  write strobe on the acknowledging edge. Assumes a master that holds the
  request until it samples ack and then drops cyc/stb for a cycle.
*/
`timescale 1ns/1ns
module wb_access_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  output logic ack_out,
  output logic rd_cap_out,
  output logic wr_out
);

  logic req;

  assign req = cyc_in && stb_in;

  // ------------------------------------------------------------
  // ack one cycle after the request, dropped after one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= req && !ack_out;
    end
  end

  // read data is latched together with ack; write lands on the ack edge
  assign rd_cap_out = req && !ack_out;
  assign wr_out = req && we_in && ack_out;

endmodule

// ==== hdl/pad_drive_slew_pull_regs.sv ====
/*
  Pad drive/slew/pull register bank for six control and audio transmit pins,
  reached over classic Wishbone. Assumes a 25 MHz system clock and an
  asynchronous active-high reset; pad outputs are static configuration.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
module pad_drive_slew_pull_regs (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [pad_regs_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [pad_regs_pkg::SEL_W-1:0] WB_SEL_IN,
  input wire logic [pad_regs_pkg::BUS_W-1:0] WB_DAT_IN,
  output logic [pad_regs_pkg::BUS_W-1:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output pad_regs_pkg::pad_cfg_t AUDIO_TX_OUT_PIN_CFG_OUT,
  output pad_regs_pkg::pad_cfg_t CTRL_CLOCK_PIN_CFG_OUT,
  output pad_regs_pkg::pad_cfg_t CTRL_DATAOUT_PIN_CFG_OUT,
  output pad_regs_pkg::pad_cfg_t SELECT_ADDR0_PIN_CFG_OUT,
  output pad_regs_pkg::pad_cfg_t DATAIN_ADDR1_PIN_CFG_OUT,
  output pad_regs_pkg::pad_cfg_t MASTER_CTRL_CLOCK_PIN_CFG_OUT
);

  // ------------------------------------------------------------
  // register table
  // ------------------------------------------------------------
  localparam logic [pad_regs_pkg::IDX_W-1:0] IDX_TABLE [pad_regs_pkg::NUM_REGS] = '{
    pad_regs_pkg::AUDIO_TX_PAD_CTRL_IDX,
    pad_regs_pkg::CTRL_CLOCK_PAD_CTRL_IDX,
    pad_regs_pkg::CTRL_DATAOUT_PAD_CTRL_IDX,
    pad_regs_pkg::SELECT_ADDR0_PAD_CTRL_IDX,
    pad_regs_pkg::DATAIN_ADDR1_PAD_CTRL_IDX,
    pad_regs_pkg::MASTER_CLOCK_PAD_CTRL_IDX
  };
  // audio transmit pull is a pull-down, the rest pull-ups; only the two
  // address straps start with the pull enabled
  localparam logic [pad_regs_pkg::REG_W-1:0] RESET_TABLE [pad_regs_pkg::NUM_REGS] = '{
    pad_regs_pkg::RESET_PULL_OFF,
    pad_regs_pkg::RESET_PULL_OFF,
    pad_regs_pkg::RESET_PULL_OFF,
    pad_regs_pkg::RESET_PULL_ON,
    pad_regs_pkg::RESET_PULL_ON,
    pad_regs_pkg::RESET_PULL_OFF
  };

  logic [pad_regs_pkg::IDX_W-1:0] word_idx;
  logic [pad_regs_pkg::NUM_REGS-1:0] hit;
  logic [pad_regs_pkg::REG_W-1:0] value [pad_regs_pkg::NUM_REGS];
  logic [pad_regs_pkg::REG_W-1:0] rd_mux;
  logic rd_cap;
  logic wr;
  logic [pad_regs_pkg::BUS_W-1:0] dat_out_reg;

  assign word_idx = WB_ADR_IN[pad_regs_pkg::ADR_W-1:pad_regs_pkg::ADR_IDX_LSB];

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  wb_access_ctrl u_access (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .cyc_in(WB_CYC_IN),
    .stb_in(WB_STB_IN),
    .we_in(WB_WE_IN),
    .ack_out(WB_ACK_OUT),
    .rd_cap_out(rd_cap),
    .wr_out(wr)
  );

  // ------------------------------------------------------------
  // registers, one per pad
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < pad_regs_pkg::NUM_REGS; i = i + 1) begin : g_reg
      assign hit[i] = (word_idx == IDX_TABLE[i]);
      pad_cfg_reg #(
        .RESET_VAL(RESET_TABLE[i])
      ) u_reg (
        .clk_in(REF_CLK_IN),
        .rst_in(SYS_RST_IN),
        .wr_in(wr && hit[i]),
        .sel_in(WB_SEL_IN[1:0]),
        .dat_in(WB_DAT_IN[pad_regs_pkg::REG_W-1:0]),
        .value_out(value[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read path; unmapped words answer zero and ignore writes
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    for (int k = 0; k < pad_regs_pkg::NUM_REGS; k++) begin
      if (hit[k]) begin
        rd_mux = value[k];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dat_out_reg <= '0;
    end else if (rd_cap) begin
      dat_out_reg <= {16'h0000, rd_mux};
    end
  end

  assign WB_DAT_OUT = dat_out_reg;

  // ------------------------------------------------------------
  // pad fields: straight from the register flops, so a write shows on the
  // pads right after its acknowledging edge with no extra stage
  // ------------------------------------------------------------
  function automatic pad_regs_pkg::pad_cfg_t to_cfg(input logic [pad_regs_pkg::REG_W-1:0] v);
    pad_regs_pkg::pad_cfg_t c;
    c.pull_en = v[pad_regs_pkg::PULL_BIT];
    c.slew = pad_regs_pkg::slew_t'(v[pad_regs_pkg::SLEW_MSB:pad_regs_pkg::SLEW_LSB]);
    c.drive = pad_regs_pkg::drive_t'(v[pad_regs_pkg::DRIVE_MSB:pad_regs_pkg::DRIVE_LSB]);
    return c;
  endfunction

  assign AUDIO_TX_OUT_PIN_CFG_OUT = to_cfg(value[0]);
  assign CTRL_CLOCK_PIN_CFG_OUT = to_cfg(value[1]);
  assign CTRL_DATAOUT_PIN_CFG_OUT = to_cfg(value[2]);
  assign SELECT_ADDR0_PIN_CFG_OUT = to_cfg(value[3]);
  assign DATAIN_ADDR1_PIN_CFG_OUT = to_cfg(value[4]);
  assign MASTER_CTRL_CLOCK_PIN_CFG_OUT = to_cfg(value[5]);

endmodule

// ==== dv/pad_regs_sva.sv ====
/*
  Port checker for the pad register bank: bus handshake, write timing and read data.
  Assumes one clock and the asynchronous active-high reset of the top module.
*/
`timescale 1ns/1ns
module pad_regs_sva (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [pad_regs_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [pad_regs_pkg::SEL_W-1:0] WB_SEL_IN,
  input wire logic [pad_regs_pkg::BUS_W-1:0] WB_DAT_IN,
  input wire logic [pad_regs_pkg::BUS_W-1:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire pad_regs_pkg::pad_cfg_t AUDIO_TX_OUT_PIN_CFG_OUT,
  input wire pad_regs_pkg::pad_cfg_t CTRL_CLOCK_PIN_CFG_OUT,
  input wire pad_regs_pkg::pad_cfg_t CTRL_DATAOUT_PIN_CFG_OUT,
  input wire pad_regs_pkg::pad_cfg_t SELECT_ADDR0_PIN_CFG_OUT,
  input wire pad_regs_pkg::pad_cfg_t DATAIN_ADDR1_PIN_CFG_OUT,
  input wire pad_regs_pkg::pad_cfg_t MASTER_CTRL_CLOCK_PIN_CFG_OUT
);
  // --------------------------------
  // helpers and assertions
  // --------------------------------
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire logic req = WB_CYC_IN && WB_STB_IN;
  wire logic [15:0] idx = WB_ADR_IN[17:2];
  wire logic [4:0] wlow = WB_DAT_IN[4:0];
  // only the low lane carries the pad fields
  wire logic wr = WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0];
  wire logic rd = WB_ACK_OUT && !WB_WE_IN;
  wire logic [29:0] all = {MASTER_CTRL_CLOCK_PIN_CFG_OUT, DATAIN_ADDR1_PIN_CFG_OUT, SELECT_ADDR0_PIN_CFG_OUT,
    CTRL_DATAOUT_PIN_CFG_OUT, CTRL_CLOCK_PIN_CFG_OUT, AUDIO_TX_OUT_PIN_CFG_OUT};
  a_req_answered: assert property (req && !WB_ACK_OUT |=> WB_ACK_OUT) else $error("no ack");
  a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
  a_ack_needs_req: assert property (!req |=> !WB_ACK_OUT) else $error("stray ack");
  a_audio_write: assert property (wr && idx == pad_regs_pkg::AUDIO_TX_PAD_CTRL_IDX
    |=> AUDIO_TX_OUT_PIN_CFG_OUT == $past(wlow)) else $error("audio pad not updated");
  a_select_write: assert property (wr && idx == pad_regs_pkg::SELECT_ADDR0_PAD_CTRL_IDX
    |=> SELECT_ADDR0_PIN_CFG_OUT == $past(wlow)) else $error("select pad not updated");
  a_master_write: assert property (wr && idx == pad_regs_pkg::MASTER_CLOCK_PAD_CTRL_IDX
    |=> MASTER_CTRL_CLOCK_PIN_CFG_OUT == $past(wlow)) else $error("master pad not updated");
  a_pads_hold: assert property (!(WB_ACK_OUT && WB_WE_IN) |=> $stable(all)) else $error("pad moved");
  a_datain_read: assert property (rd && idx == pad_regs_pkg::DATAIN_ADDR1_PAD_CTRL_IDX
    |-> WB_DAT_OUT[4:0] == DATAIN_ADDR1_PIN_CFG_OUT) else $error("read differs from pad");
  a_upper_zero: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:16] == 16'h0000) else $error("upper half set");
  c_audio_write: cover property (wr && idx == pad_regs_pkg::AUDIO_TX_PAD_CTRL_IDX);
  c_read: cover property (rd && idx == pad_regs_pkg::DATAIN_ADDR1_PAD_CTRL_IDX);
  c_unmapped: cover property (rd && idx > pad_regs_pkg::MASTER_CLOCK_PAD_CTRL_IDX);
endmodule

bind pad_drive_slew_pull_regs pad_regs_sva u_sva (.*);

// ==== dv/pad_drive_slew_pull_regs_tb.sv ====
/*
  Self-checking bench for the pad register bank: reset values, field writes, byte lanes,
  unmapped places and a second reset. Assumes the classic Wishbone slave of the top module.
*/
`timescale 1ns/1ns
module pad_drive_slew_pull_regs_tb;
  logic REF_CLK_IN = 1'b0;
  logic SYS_RST_IN = 1'b1;
  logic WB_CYC_IN = 1'b0;
  logic WB_STB_IN = 1'b0;
  logic WB_WE_IN = 1'b0;
  logic [17:0] WB_ADR_IN = 18'h00000;
  logic [3:0] WB_SEL_IN = 4'h0;
  logic [31:0] WB_DAT_IN = 32'h00000000;
  logic [31:0] WB_DAT_OUT;
  logic WB_ACK_OUT;
  pad_regs_pkg::pad_cfg_t AUDIO_TX_OUT_PIN_CFG_OUT, CTRL_CLOCK_PIN_CFG_OUT, CTRL_DATAOUT_PIN_CFG_OUT;
  pad_regs_pkg::pad_cfg_t SELECT_ADDR0_PIN_CFG_OUT, DATAIN_ADDR1_PIN_CFG_OUT, MASTER_CTRL_CLOCK_PIN_CFG_OUT;
  wire logic [29:0] cfg_all = {MASTER_CTRL_CLOCK_PIN_CFG_OUT, DATAIN_ADDR1_PIN_CFG_OUT, SELECT_ADDR0_PIN_CFG_OUT,
    CTRL_DATAOUT_PIN_CFG_OUT, CTRL_CLOCK_PIN_CFG_OUT, AUDIO_TX_OUT_PIN_CFG_OUT};
  int fails = 0;
  int checked = 0;
  logic [31:0] q;
  logic [15:0] d;
  logic [29:0] snap;
  // just outside the bank on both sides, and far away
  logic [15:0] uut_gap [3] = '{16'hf797, 16'hf79e, 16'h0000};
  pad_drive_slew_pull_regs uut (.*);
  always #20 REF_CLK_IN = ~REF_CLK_IN;
  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pad(input int i, input logic [4:0] exp);
    chk(32'(cfg_all[i*5 +: 5]), 32'(exp));
  endtask
  // entered just after an edge; leaves one idle edge so cyc/stb drop for a cycle
  task automatic bus(input logic w, input logic [15:0] ix, input logic [3:0] s, input logic [31:0] wd);
    int n;
    n = 0;
    {WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ADR_IN, WB_SEL_IN, WB_DAT_IN} <= {2'b11, w, ix, 2'b00, s, wd};
    do begin
      @(posedge REF_CLK_IN);
      n++;
    end while (WB_ACK_OUT !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("[ERR] %0t no ack within 20 cycles", $time);
      results();
    end else begin
      q = WB_DAT_OUT;
      {WB_CYC_IN, WB_STB_IN} <= 2'b00;
      @(posedge REF_CLK_IN);
    end
  endtask
  function automatic logic [15:0] ix(int i);
    return pad_regs_pkg::AUDIO_TX_PAD_CTRL_IDX + 16'(i);
  endfunction
  function automatic logic [15:0] rv(int i);
    return (i == 3 || i == 4) ? 16'h0018 : 16'h0008;
  endfunction
  task automatic check_reset();
    for (int i = 0; i < 6; i++) begin
      chk_pad(i, 5'(rv(i)));
      bus(1'b0, ix(i), 4'hf, 32'h00000000);
      chk(q, {16'h0000, rv(i)});
    end
    $display("test reset values done");
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge REF_CLK_IN);
    SYS_RST_IN <= 1'b0;
    @(posedge REF_CLK_IN);
    check_reset();
    for (int i = 0; i < 6; i++) begin
      for (int c = 0; c < 4; c++) begin
        d = {c[0] ? 11'h555 : 11'h2aa, c[0], c[1:0], ~c[1:0]};
        bus(1'b1, ix(i), 4'hf, {16'hdead, d});
        chk_pad(i, d[4:0]);
        bus(1'b0, ix(i), 4'hf, 32'h00000000);
        chk(q, {16'h0000, d});
      end
      bus(1'b1, ix(i), 4'h2, 32'h00000000);
      chk_pad(i, d[4:0]);
      bus(1'b0, ix(i), 4'hf, 32'h00000000);
      chk(q, {24'h000000, d[7:0]});
    end
    $display("test field writes done");
    snap = cfg_all;
    foreach (uut_gap[k]) begin
      bus(1'b1, uut_gap[k], 4'hf, 32'h0000ffff);
      bus(1'b0, uut_gap[k], 4'hf, 32'h00000000);
      chk(q, 32'h00000000);
    end
    chk(32'(cfg_all), 32'(snap));
    $display("test unmapped done");
    SYS_RST_IN <= 1'b1;
    repeat (2) @(posedge REF_CLK_IN);
    SYS_RST_IN <= 1'b0;
    @(posedge REF_CLK_IN);
    check_reset();
    results();
  end
endmodule
